// *** pis_sched.sv ***
// Decided for this implementation: the address map and the APB slave port.
`include "pis_params.svh"
`default_nettype none

module pis_sched
  import pis_pkg::*;
(
  input wire logic i_clk_sys, // 50 MHz clock
  input wire logic i_rst, // Async reset, high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [3:0] i_irq_line, // Backplane lines, high active
  input wire logic [8:0] i_time_req, // Time base pulses, 0 fastest
  input wire logic i_block_bnd, // Block boundary strobe
  input wire logic i_op_bnd, // Operation boundary strobe
  input wire logic i_handler_done, // Block end of running handler
  input wire logic i_irq_disable_op, // Disable operation strobe
  input wire logic i_irq_enable_op, // Enable operation strobe
  input wire logic i_in_func_block, // Core is inside a function block
  input wire logic i_error, // Program or device error
  input wire logic i_operator_stop, // Operator stop or halt
  input wire logic i_halt_op, // Halt operation executed
  output logic o_call_process, // Pulse: start process handler
  output logic o_call_time, // Pulse: start time handler
  output logic [3:0] o_time_level, // Time base of o_call_time
  output logic o_resume, // Pulse: resume suspended program
  output logic o_abort // Pulse: handlers aborted
);

  pis_state_t q;
  pis_state_t next_q;

  ////////////////////////////////////////////////////////////////////////
  // Lowest set bit to index
  function automatic logic [3:0] pis_low_idx(input logic [8:0] v);
    logic [3:0] r;
    r = `PIS_L0;
    for (int i = `PIS_NTIME - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  logic [8:0] time_hit;
  genvar gi;
  generate
    for (gi = 0; gi < `PIS_NTIME; gi++) begin : g_tset
      // Set wins over start-clear in the same cycle
      assign time_hit[gi] = i_time_req[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  logic line;
  logic rise;
  logic bnd;
  logic kill;
  logic proc_go;
  logic [8:0] run_low;
  logic [8:0] elig;
  logic apb_setup;
  logic hit_ctrl;
  logic hit_stat;

  always_comb begin
    next_q = q;
    next_q.call_p = 1'b0;
    next_q.call_t = 1'b0;
    next_q.resume = 1'b0;
    next_q.abort = 1'b0;
    next_q.pready = 1'b0;
    next_q.pslverr = 1'b0;

    // Pin sync; accept a change once stages two and three agree
    next_q.s1 = i_irq_line;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < `PIS_NLINE; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        next_q.line_f[i] = q.s3[i];
      end
    end
    line = q.line_f[q.slot];
    next_q.line_q = line;
    rise = line & ~q.line_q;

    // Insertion points follow configured granularity
    bnd = q.op_mode ? (i_op_bnd | i_block_bnd) : i_block_bnd;
    kill = (i_error & i_op_bnd) | i_operator_stop | i_halt_op;

    // Disable window only honoured inside function blocks
    if (i_irq_disable_op & i_in_func_block) begin
      next_q.dis = 1'b1;
    end else if (i_irq_enable_op & i_in_func_block) begin
      next_q.dis = 1'b0;
    end

    // Level re-arm: inactive line allows a new level request
    if (!q.proc_act && !line) begin
      next_q.lvl_ok = 1'b1;
    end

    // Request latch; line is ignored while process handler runs, no overflow
    if (q.installed && !q.proc_act) begin
      if (rise) begin
        next_q.pend = 1'b1;
      end else if (!q.edge_mode && line && q.lvl_ok) begin
        next_q.pend = 1'b1;
      end
    end
    if (!q.installed) begin
      next_q.pend = 1'b0;
    end

    // Time requests stay pending until started
    next_q.tpend = q.tpend | time_hit;

    run_low = q.trun & (~q.trun + 9'h001);
    elig = (q.trun == `PIS_T0) ? q.tpend : (q.tpend & (run_low - 9'h001));
    proc_go = q.pend & q.installed & ~q.dis & ~q.proc_act;

    if (kill) begin
      next_q.proc_act = 1'b0;
      next_q.trun = `PIS_T0;
      next_q.pend = 1'b0;
      next_q.lvl_ok = 1'b0;
      next_q.abort = 1'b1;
      next_q.kind = PIS_K_NONE;
    end else if (i_handler_done) begin
      next_q.resume = 1'b1;
      if (q.proc_act) begin
        next_q.proc_act = 1'b0;
        next_q.lvl_ok = 1'b0;
        // Still active at block end: request again, one block later
        if (!q.edge_mode && line && q.installed) begin
          next_q.pend = 1'b1;
        end
        next_q.kind = (q.trun != `PIS_T0) ? PIS_K_TIME : PIS_K_NONE;
      end else begin
        next_q.trun = q.trun & (q.trun - 9'h001);
        next_q.kind = ((q.trun & (q.trun - 9'h001)) != `PIS_T0) ? PIS_K_TIME
                                                                : PIS_K_NONE;
      end
    end else if (bnd && proc_go) begin
      next_q.call_p = 1'b1;
      next_q.proc_act = 1'b1;
      next_q.pend = 1'b0;
      next_q.lvl_ok = 1'b0;
      next_q.kind = PIS_K_PROC;
    end else if (bnd && !q.proc_act && !q.pend && elig != `PIS_T0) begin
      // Time handlers wait for all process work
      next_q.call_t = 1'b1;
      next_q.tlev = pis_low_idx(elig);
      next_q.trun = q.trun | (elig & (~elig + 9'h001));
      next_q.tpend = (q.tpend & ~(elig & (~elig + 9'h001))) | time_hit;
      next_q.kind = PIS_K_TIME;
    end

    // APB: zero wait, answer in first access cycle
    apb_setup = psel & ~penable;
    hit_ctrl = (paddr == `PIS_A_CTRL);
    hit_stat = (paddr == `PIS_A_STAT);
    if (apb_setup) begin
      next_q.pready = 1'b1;
      next_q.prdata = `PIS_ZERO32;
      next_q.pslverr = ~(hit_ctrl | hit_stat);
      if (!pwrite && hit_ctrl) begin
        next_q.prdata[`PIS_C_EDGE] = q.edge_mode;
        next_q.prdata[`PIS_C_OPB] = q.op_mode;
        next_q.prdata[`PIS_C_INST] = q.installed;
        next_q.prdata[`PIS_C_SLOT_HI:`PIS_C_SLOT_LO] = q.slot;
      end
      if (!pwrite && hit_stat) begin
        next_q.prdata[`PIS_S_PEND] = q.pend;
        next_q.prdata[`PIS_S_PACT] = q.proc_act;
        next_q.prdata[`PIS_S_DIS] = q.dis;
        next_q.prdata[`PIS_S_KIND_HI:`PIS_S_KIND_LO] = q.kind;
        next_q.prdata[`PIS_S_TRUN_HI:`PIS_S_TRUN_LO] = q.trun;
        next_q.prdata[`PIS_S_TPND_HI:`PIS_S_TPND_LO] = q.tpend;
      end
    end
    // Write lands at the access edge the master samples pready
    if (psel && penable && q.pready && pwrite && hit_ctrl) begin
      next_q.edge_mode = pwdata[`PIS_C_EDGE];
      next_q.op_mode = pwdata[`PIS_C_OPB];
      next_q.installed = pwdata[`PIS_C_INST];
      next_q.slot = pwdata[`PIS_C_SLOT_HI:`PIS_C_SLOT_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
      q.lvl_ok <= 1'b1;
      q.kind <= PIS_K_NONE;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign o_call_process = q.call_p;
  assign o_call_time = q.call_t;
  assign o_time_level = q.tlev;
  assign o_resume = q.resume;
  assign o_abort = q.abort;

endmodule
`default_nettype wire

// *** pis_params.svh ***
`ifndef PIS_PARAMS_SVH
`define PIS_PARAMS_SVH
// Register byte addresses
`define PIS_A_CTRL 12'h000
`define PIS_A_STAT 12'h004
// Control field positions
`define PIS_C_EDGE 0
`define PIS_C_OPB 1
`define PIS_C_INST 2
`define PIS_C_SLOT_LO 4
`define PIS_C_SLOT_HI 5
// Status field positions
`define PIS_S_PEND 0
`define PIS_S_PACT 1
`define PIS_S_DIS 2
`define PIS_S_KIND_LO 4
`define PIS_S_KIND_HI 5
`define PIS_S_TRUN_LO 7
`define PIS_S_TRUN_HI 15
`define PIS_S_TPND_LO 16
`define PIS_S_TPND_HI 24
// Sizes and reset values
`define PIS_NLINE 4
`define PIS_NTIME 9
`define PIS_CTRL_RST 32'h0000_0000
`define PIS_ZERO32 32'h0000_0000
`define PIS_T0 9'h000
`define PIS_L0 4'h0
`endif

// *** pis_pkg.sv ***
`default_nettype none
package pis_pkg;
  typedef enum logic [1:0] {
    PIS_K_NONE = 2'b00,
    PIS_K_PROC = 2'b01,
    PIS_K_TIME = 2'b10
  } pis_kind_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] line_f;
    logic line_q;
    logic edge_mode;
    logic op_mode;
    logic installed;
    logic [1:0] slot;
    logic pend;
    logic lvl_ok;
    logic proc_act;
    logic dis;
    logic [8:0] tpend;
    logic [8:0] trun;
    logic call_p;
    logic call_t;
    logic [3:0] tlev;
    logic resume;
    logic abort;
    pis_kind_t kind;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pis_state_t;
endpackage
`default_nettype wire

// *** pis_sched_asserts.sv ***
`default_nettype none
module pis_sched_asserts (
  input wire logic i_clk_sys, // Clock
  input wire logic i_rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic i_block_bnd, // Block edge
  input wire logic i_op_bnd, // Op edge
  input wire logic i_handler_done, // Done
  input wire logic i_error, // Error
  input wire logic i_operator_stop, // Stop
  input wire logic i_halt_op, // Halt
  input wire logic o_call_process, // Call
  input wire logic o_call_time, // Call
  input wire logic o_resume, // Resume
  input wire logic o_abort // Abort
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic run_p;
  // Process handler open; a resume then always closes it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) run_p <= 1'b0;
    else if (o_call_process) run_p <= 1'b1;
    else if (o_resume || o_abort) run_p <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  apb_ready_a: assert property ((psel && !penable) |=> (pready ##1 !pready))
    else $error("ready not a single access pulse");
  apb_err_a: assert property (pslverr |-> pready) else $error("error without ready");
  resume_cause_a: assert property (o_resume |-> $past(i_handler_done))
    else $error("resume without done");
  call_bound_a: assert property ((o_call_process || o_call_time) |->
    $past(i_block_bnd || i_op_bnd)) else $error("call off boundary");
  no_nest_a: assert property ((o_call_process || o_call_time) |-> !run_p)
    else $error("call while process handler open");
  proc_first_a: assert property (o_call_time |-> !o_call_process)
    else $error("time and process called together");
  abort_cause_a: assert property (o_abort |->
    $past(i_operator_stop || i_halt_op || (i_error && i_op_bnd))) else $error("bad abort");
  done_gap_a: assert property ($past(i_handler_done) |-> !o_call_process)
    else $error("call on done cycle");
  cover property (o_call_process);
  cover property (o_call_time);
  cover property (o_abort);
endmodule
bind pis_sched pis_sched_asserts i_pis_sched_asserts (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .i_block_bnd(i_block_bnd), .i_op_bnd(i_op_bnd), .i_handler_done(i_handler_done),
  .i_error(i_error), .i_operator_stop(i_operator_stop), .i_halt_op(i_halt_op),
  .o_call_process(o_call_process), .o_call_time(o_call_time), .o_resume(o_resume),
  .o_abort(o_abort));
`default_nettype wire

// *** pis_irq_src.sv ***
`default_nettype none
module pis_irq_src (
  input wire logic i_clk_sys, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_fire, // Raise request
  input wire logic i_clr, // Drop request
  input wire logic [1:0] i_slot, // Line used
  output logic [3:0] o_line // Backplane lines
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold;
  // Held until cleared by software on the module side
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) hold <= 1'b0;
    else if (i_fire) hold <= 1'b1;
    else if (i_clr) hold <= 1'b0;
  end
  assign o_line = hold ? (4'h1 << i_slot) : 4'h0;
endmodule
`default_nettype wire

// *** pis_sched_tb_top.sv ***
`default_nettype none
module pis_sched_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 0, i_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] line, tl;
  logic [8:0] treq = 9'h000;
  logic bb = 0, ob = 0, hd = 0, dis = 0, ena = 0, infb = 0, halt_op = 0, fire = 0, clr = 0;
  logic err = 0, hlt = 0;
  logic cp, ct, rs, ab;
  logic [1:0] slot = 2'h0;
  int num_errors = 0, n_checks = 0;
  always #10 i_clk_sys = ~i_clk_sys;
  pis_irq_src i_pis_irq_src (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_fire(fire),
    .i_clr(clr), .i_slot(slot), .o_line(line));
  pis_sched i_pis_sched (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_irq_line(line), .i_time_req(treq),
    .i_block_bnd(bb), .i_op_bnd(ob), .i_handler_done(hd), .i_irq_disable_op(dis),
    .i_irq_enable_op(ena), .i_in_func_block(infb), .i_error(err),
    .i_operator_stop(halt_op), .i_halt_op(hlt), .o_call_process(cp), .o_call_time(ct),
    .o_time_level(tl), .o_resume(rs), .o_abort(ab));
  ////////////////////////////////////////////////////////////////
  task finish_test;
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x);
    int n;
    logic [31:0] r;
    logic e;
    n = 0;
    @(posedge i_clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1;
    @(posedge i_clk_sys);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        num_errors++;
        finish_test;
      end
      @(posedge i_clk_sys);
    end
    // Answer is taken at the edge that samples pready high
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (!w) chk(r, x);
    chk({31'h0, e}, {31'h0, a > 12'h004});
  endtask
  // Strobe for one cycle, then look at the call and resume pulses
  task core(input logic [1:0] b, input logic d, input logic [2:0] x);
    @(posedge i_clk_sys);
    bb <= b[0];
    ob <= b[1];
    hd <= d;
    @(posedge i_clk_sys);
    bb <= 0;
    ob <= 0;
    hd <= 0;
    #1 chk({29'h0, cp, ct, rs}, {29'h0, x});
  endtask
  // Line needs four clocks to pass the filter, so wait longer
  task src(input logic f, input logic c);
    @(posedge i_clk_sys);
    fire <= f;
    clr <= c;
    @(posedge i_clk_sys);
    fire <= 0;
    clr <= 0;
    wt(8);
  endtask
  task op(input logic d);
    @(posedge i_clk_sys);
    dis <= d;
    ena <= !d;
    infb <= 1;
    @(posedge i_clk_sys);
    dis <= 0;
    ena <= 0;
  endtask
  // Abort causes for one cycle: k = {op boundary, halt, stop, error}
  task abt(input logic [3:0] k, input logic x);
    @(posedge i_clk_sys);
    err <= k[0];
    halt_op <= k[1];
    hlt <= k[2];
    ob <= k[3];
    @(posedge i_clk_sys);
    err <= 0;
    halt_op <= 0;
    hlt <= 0;
    ob <= 0;
    #1 chk({31'h0, ab}, {31'h0, x});
  endtask
  initial begin
    wt(20000);
    num_errors++;
    finish_test;
  end
  initial begin
    wt(2);
    i_rst <= 0;
    apb(0, 12'h000, 32'h0, 32'h0);
    apb(0, 12'h004, 32'h0, 32'h0);
    apb(0, 12'h010, 32'h0, 32'h0);
    apb(1, 12'h004, 32'hFF, 32'h0);
    slot <= 2'h2;
    src(1, 0);
    core(2'b01, 0, 3'b000);
    src(0, 1);
    apb(1, 12'h000, 32'h24, 32'h0);
    slot <= 2'h1;
    src(1, 0);
    core(2'b01, 0, 3'b000);
    src(0, 1);
    slot <= 2'h2;
    src(1, 0);
    src(0, 1);
    core(2'b01, 0, 3'b100);
    apb(0, 12'h004, 32'h0, 32'h12);
    src(1, 0);
    treq <= 9'h028;
    @(posedge i_clk_sys);
    treq <= 9'h000;
    core(2'b01, 0, 3'b000);
    core(2'b00, 1, 3'b001);
    core(2'b01, 0, 3'b100);
    src(0, 1);
    core(2'b00, 1, 3'b001);
    core(2'b01, 0, 3'b010);
    chk({28'h0, tl}, 32'h3);
    core(2'b00, 1, 3'b001);
    core(2'b01, 0, 3'b010);
    chk({28'h0, tl}, 32'h5);
    core(2'b00, 1, 3'b001);
    core(2'b01, 0, 3'b000);
    op(1);
    src(1, 0);
    core(2'b01, 0, 3'b000);
    op(0);
    core(2'b10, 0, 3'b000);
    core(2'b01, 0, 3'b100);
    src(0, 1);
    core(2'b00, 1, 3'b001);
    apb(1, 12'h000, 32'h27, 32'h0);
    src(1, 0);
    core(2'b10, 0, 3'b100);
    core(2'b00, 1, 3'b001);
    core(2'b01, 0, 3'b000);
    src(0, 1);
    src(1, 0);
    core(2'b10, 0, 3'b100);
    core(2'b00, 1, 3'b001);
    src(0, 1);
    treq <= 9'h004;
    @(posedge i_clk_sys);
    treq <= 9'h000;
    core(2'b10, 0, 3'b010);
    chk({28'h0, tl}, 32'h2);
    src(1, 0);
    core(2'b10, 0, 3'b100);
    apb(0, 12'h004, 32'h0, 32'h212);
    core(2'b00, 1, 3'b001);
    apb(0, 12'h004, 32'h0, 32'h220);
    core(2'b00, 1, 3'b001);
    src(0, 1);
    src(1, 0);
    core(2'b10, 0, 3'b100);
    abt(4'b0001, 0);
    abt(4'b0010, 1);
    apb(0, 12'h004, 32'h0, 32'h0);
    abt(4'b1001, 1);
    abt(4'b0100, 1);
    finish_test;
  end
endmodule
`default_nettype wire
